// ---- pwmc_pkg.sv ----
// Package with constants and types of the four-channel pulse-width core.
`default_nettype none
package pwmc_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] OFS_ENABLE = 8'h00;
   localparam logic [7:0] OFS_POLARITY = 8'h04;
   localparam logic [7:0] OFS_CLK_CHOICE = 8'h08;
   localparam logic [7:0] OFS_ALIGN_MODE = 8'h0c;
   localparam logic [7:0] OFS_PAIR_JOIN = 8'h10;
   localparam logic [7:0] OFS_SHUTDOWN = 8'h14;
   localparam logic [7:0] OFS_CNT_BASE = 8'h20;
   localparam logic [7:0] OFS_PER_BASE = 8'h30;
   localparam logic [7:0] OFS_DTY_BASE = 8'h40;
   localparam logic [7:0] OFS_JCNT_LOWER = 8'h50;
   localparam logic [7:0] OFS_JCNT_UPPER = 8'h54;
   localparam logic [7:0] OFS_GROUP_MASK = 8'hf0;
   localparam int CH_IDX_LSB = 2;

   // ****************************************
   // Field positions and reset values
   // ****************************************
   localparam int JOIN_LOWER_BIT = 0;
   localparam int JOIN_UPPER_BIT = 1;
   localparam int SDN_IRQ_EN_BIT = 0;
   localparam int SDN_PIN_BIT = 1;
   localparam int NUM_CH = 4;
   localparam int NUM_PAIRS = 2;
   localparam logic [3:0] FF_RESET = 4'hf;
   localparam logic [15:0] CNT_ZERO = 16'h0000;
   localparam logic [15:0] CNT_ONE = 16'h0001;

   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } pwmc_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } pwmc_apb_rsp_t;

   typedef struct packed {
      logic a;
      logic sa;
      logic b;
      logic sb;
   } pwmc_tick_t;

   typedef struct packed {
      logic [15:0] cnt;
      logic down;
      logic ff;
      logic load;
   } pwmc_step_t;

   typedef struct packed {
      logic [3:0][7:0] cnt;
      logic [3:0][7:0] per_act;
      logic [3:0][7:0] dty_act;
      logic [3:0][7:0] per_buf;
      logic [3:0][7:0] dty_buf;
      logic [3:0] down;
      logic [3:0] ff;
      logic [3:0] wave;
      logic [3:0] en;
      logic [3:0] pol;
      logic [3:0] clk_sel;
      logic [3:0] align;
      logic [3:0] eff_prev;
      logic [1:0] join_pair;
      logic sdn_irq_en;
      logic [1:0] sdn_sync;
      logic irq;
      logic [31:0] prdata;
   } pwmc_state_t;

   localparam pwmc_state_t STATE_RESET = '{ff: FF_RESET, default: '0};

endpackage : pwmc_pkg
`default_nettype wire

// ---- pwmc_core.sv ----
// Four-channel pulse-width generator with pair joining and an APB slave.
//
// Overview of operation
// - Align select bit 0 gives left-aligned, 1 gives centre-aligned.
// - Left-aligned counter only counts upward.
// - Counter equal to duty toggles the output flip-flop in both modes.
// - Left-aligned period match clears counter, resets flip-flop, loads buffers.
// - Left-aligned count runs 0 to period minus one.
// - Centre-aligned counts up and down, forced upward at zero.
// - Centre-aligned period match turns direction downward, no clear.
// - Centre-aligned downward duty match toggles the output again.
// - Centre-aligned reaching zero downward turns upward and loads buffers.
// - Centre-aligned period spans twice the period value.
// - High fraction is duty/period for polarity 1, else the rest.
// - One join bit pairs channels 2 and 3, another 0 and 1.
// - In a pair the lower channel number holds the high byte.
// - Joined pair uses clock choice of its low-order channel.
// - Joined pair drives only low-order pin with low-order polarity.
// - Joined pair enabled by low-order bit; high-order output held off.
// - Any write to either byte of a joined counter clears it.
// - Joined pair alignment follows the low-order select bit.
// - Duty zero gives inactive level; duty at or above period active.
// - Period zero holds counter at zero and output at active level.
// - After reset counters count up, channels disabled, nothing counts.
// - Module interrupt disabled while shutdown interrupt enable is clear.
// - Counter write clears it, counts up, loads buffers, sets start level.
// - Period and duty writes buffered while enabled, direct while disabled.
// - Polarity 1 starts high and drops at duty; polarity 0 inverse.
// - Disabled counter holds its value and resumes on re-enable.
//
// Our own choices: the register offsets and the APB slave port.
`default_nettype none
module pwmc_core (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // APB register port.
   input wire pwmc_pkg::pwmc_apb_req_t apb_req,
   output pwmc_pkg::pwmc_apb_rsp_t apb_rsp,
   // Prescaled clock ticks, one-cycle pulses from the same clock.
   input wire pwmc_pkg::pwmc_tick_t tick,
   // Shutdown input pin.
   input wire logic shutdown_pin,
   // Pins and interrupt.
   output logic [3:0] wave_output,
   output logic irq
);
   import pwmc_pkg::*;

   pwmc_state_t s_r;
   pwmc_state_t s_nxt;

   // ****************************************
   // Functions
   // ****************************************

   // One counting step on a selected clock tick.
   function automatic pwmc_step_t chan_step(input logic [15:0] cnt,
                                            input logic [15:0] per,
                                            input logic [15:0] dty,
                                            input logic down,
                                            input logic ff,
                                            input logic center);
      pwmc_step_t st;
      logic [15:0] nx;
      st.cnt = cnt;
      st.down = down;
      st.ff = ff;
      st.load = 1'b0;
      nx = CNT_ZERO;
      if (per == CNT_ZERO) begin
         st.cnt = CNT_ZERO;
         st.down = 1'b0;
      end else if (!center) begin
         nx = cnt + CNT_ONE;
         if (nx >= per) begin
            st.cnt = CNT_ZERO;
            st.ff = 1'b1;
            st.down = 1'b0;
            st.load = 1'b1;
         end else begin
            st.cnt = nx;
            if (nx == dty) begin
               st.ff = ~ff;
            end
         end
      end else begin
         if (down && cnt != CNT_ZERO) begin
            nx = cnt - CNT_ONE;
            st.cnt = nx;
            if (nx == dty) begin
               st.ff = ~ff;
            end
            if (nx == CNT_ZERO) begin
               st.down = 1'b0;
               st.ff = 1'b1;
               st.load = 1'b1;
            end
         end else begin
            nx = cnt + CNT_ONE;
            st.cnt = nx;
            st.down = 1'b0;
            if (nx == dty) begin
               st.ff = ~ff;
            end
            if (nx >= per) begin
               st.down = 1'b1;
            end
         end
      end
      return st;
   endfunction : chan_step

   // Pin level from active values, flip-flop and polarity.
   function automatic logic out_level(input logic [15:0] per,
                                      input logic [15:0] dty,
                                      input logic ff,
                                      input logic pol);
      logic lvl;
      if (per == CNT_ZERO) begin
         lvl = 1'b1;
      end else if (dty == CNT_ZERO) begin
         lvl = 1'b0;
      end else if (dty >= per) begin
         lvl = 1'b1;
      end else begin
         lvl = ff;
      end
      return pol ? lvl : ~lvl;
   endfunction : out_level

   // Selected tick of a channel of a given pair.
   function automatic logic tick_sel(input int pair,
                                     input logic sel,
                                     input pwmc_tick_t t);
      if (pair == 0) begin
         return sel ? t.sa : t.a;
      end
      return sel ? t.sb : t.b;
   endfunction : tick_sel

   // Address decode.
   function automatic logic is_mapped(input logic [7:0] a);
      logic [7:0] grp;
      grp = a & OFS_GROUP_MASK;
      return a == OFS_ENABLE || a == OFS_POLARITY ||
             a == OFS_CLK_CHOICE || a == OFS_ALIGN_MODE ||
             a == OFS_PAIR_JOIN || a == OFS_SHUTDOWN ||
             a == OFS_JCNT_LOWER || a == OFS_JCNT_UPPER ||
             ((grp == OFS_CNT_BASE || grp == OFS_PER_BASE ||
               grp == OFS_DTY_BASE) && a[1:0] == 2'b00);
   endfunction : is_mapped

   // Read data of a register.
   function automatic logic [31:0] rd_data(input logic [7:0] a,
                                           input pwmc_state_t s);
      logic [31:0] d;
      logic [1:0] c;
      d = 32'h0000_0000;
      c = a[CH_IDX_LSB +: 2];
      unique case (a & OFS_GROUP_MASK)
         OFS_CNT_BASE: d[7:0] = s.cnt[c];
         OFS_PER_BASE: d[7:0] = s.per_buf[c];
         OFS_DTY_BASE: d[7:0] = s.dty_buf[c];
         default: begin
            unique case (a)
               OFS_ENABLE: d[3:0] = s.en;
               OFS_POLARITY: d[3:0] = s.pol;
               OFS_CLK_CHOICE: d[3:0] = s.clk_sel;
               OFS_ALIGN_MODE: d[3:0] = s.align;
               OFS_PAIR_JOIN: d[1:0] = s.join_pair;
               OFS_SHUTDOWN: begin
                  d[SDN_IRQ_EN_BIT] = s.sdn_irq_en;
                  d[SDN_PIN_BIT] = s.sdn_sync[1];
               end
               OFS_JCNT_LOWER: d[15:0] = {s.cnt[0], s.cnt[1]};
               OFS_JCNT_UPPER: d[15:0] = {s.cnt[2], s.cnt[3]};
               default: d = 32'h0000_0000;
            endcase
         end
      endcase
      return d;
   endfunction : rd_data

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin : next_state
      logic wr;
      logic [1:0] ch;
      logic [7:0] grp;
      logic [3:0] eff;
      logic [3:0] clr;
      logic [3:0] ld;
      pwmc_step_t st;
      int lo;
      int hi;
      wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
      ch = apb_req.paddr[CH_IDX_LSB +: 2];
      grp = apb_req.paddr & OFS_GROUP_MASK;
      eff = '0;
      clr = '0;
      ld = '0;
      st = '0;
      lo = 0;
      hi = 0;
      s_nxt = s_r;

      // Counting engines.
      for (int p = 0; p < NUM_PAIRS; p++) begin
         hi = 2 * p;
         lo = 2 * p + 1;
         if (s_r.join_pair[p]) begin
            eff[hi] = s_r.en[lo];
            eff[lo] = s_r.en[lo];
            if (s_r.en[lo] && tick_sel(p, s_r.clk_sel[lo], tick)) begin
               st = chan_step({s_r.cnt[hi], s_r.cnt[lo]},
                              {s_r.per_act[hi], s_r.per_act[lo]},
                              {s_r.dty_act[hi], s_r.dty_act[lo]},
                              s_r.down[lo], s_r.ff[lo], s_r.align[lo]);
               s_nxt.cnt[hi] = st.cnt[15:8];
               s_nxt.cnt[lo] = st.cnt[7:0];
               s_nxt.down[lo] = st.down;
               s_nxt.ff[lo] = st.ff;
               ld[hi] = st.load;
               ld[lo] = st.load;
            end
         end else begin
            for (int k = 0; k < 2; k++) begin
               lo = 2 * p + k;
               eff[lo] = s_r.en[lo];
               if (s_r.en[lo] && tick_sel(p, s_r.clk_sel[lo], tick)) begin
                  st = chan_step({8'h00, s_r.cnt[lo]},
                                 {8'h00, s_r.per_act[lo]},
                                 {8'h00, s_r.dty_act[lo]},
                                 s_r.down[lo], s_r.ff[lo], s_r.align[lo]);
                  s_nxt.cnt[lo] = st.cnt[7:0];
                  s_nxt.down[lo] = st.down;
                  s_nxt.ff[lo] = st.ff;
                  ld[lo] = st.load;
               end
            end
         end
      end

      // Buffers load when a channel is switched off.
      for (int c = 0; c < NUM_CH; c++) begin
         s_nxt.eff_prev[c] = eff[c];
         if (s_r.eff_prev[c] && !eff[c]) begin
            ld[c] = 1'b1;
         end
      end

      // Register writes.
      if (wr) begin
         if (grp == OFS_CNT_BASE && apb_req.paddr[1:0] == 2'b00) begin
            if (s_r.join_pair[ch[1]]) begin
               clr[{ch[1], 1'b0}] = 1'b1;
               clr[{ch[1], 1'b1}] = 1'b1;
            end else begin
               clr[ch] = 1'b1;
            end
         end
         if (grp == OFS_PER_BASE && apb_req.paddr[1:0] == 2'b00) begin
            s_nxt.per_buf[ch] = apb_req.pwdata[7:0];
            if (!eff[ch]) begin
               s_nxt.per_act[ch] = apb_req.pwdata[7:0];
            end
         end
         if (grp == OFS_DTY_BASE && apb_req.paddr[1:0] == 2'b00) begin
            s_nxt.dty_buf[ch] = apb_req.pwdata[7:0];
            if (!eff[ch]) begin
               s_nxt.dty_act[ch] = apb_req.pwdata[7:0];
            end
         end
         unique case (apb_req.paddr)
            OFS_ENABLE: s_nxt.en = apb_req.pwdata[3:0];
            OFS_POLARITY: s_nxt.pol = apb_req.pwdata[3:0];
            OFS_CLK_CHOICE: s_nxt.clk_sel = apb_req.pwdata[3:0];
            OFS_ALIGN_MODE: s_nxt.align = apb_req.pwdata[3:0];
            OFS_PAIR_JOIN: s_nxt.join_pair = apb_req.pwdata[1:0];
            OFS_SHUTDOWN: s_nxt.sdn_irq_en = apb_req.pwdata[SDN_IRQ_EN_BIT];
            OFS_JCNT_LOWER: clr[1:0] = 2'b11;
            OFS_JCNT_UPPER: clr[3:2] = 2'b11;
            default: ;
         endcase
      end

      // Counter clear and buffer load.
      for (int c = 0; c < NUM_CH; c++) begin
         if (clr[c]) begin
            s_nxt.cnt[c] = 8'h00;
            s_nxt.down[c] = 1'b0;
            s_nxt.ff[c] = 1'b1;
         end
         if (clr[c] || ld[c]) begin
            s_nxt.per_act[c] = s_nxt.per_buf[c];
            s_nxt.dty_act[c] = s_nxt.dty_buf[c];
         end
      end

      // Pin levels from the next state.
      for (int p = 0; p < NUM_PAIRS; p++) begin
         hi = 2 * p;
         lo = 2 * p + 1;
         if (s_r.join_pair[p]) begin
            s_nxt.wave[hi] = 1'b0;
            s_nxt.wave[lo] = s_r.en[lo] &
               out_level({s_nxt.per_act[hi], s_nxt.per_act[lo]},
                         {s_nxt.dty_act[hi], s_nxt.dty_act[lo]},
                         s_nxt.ff[lo], s_r.pol[lo]);
         end else begin
            for (int k = 0; k < 2; k++) begin
               lo = 2 * p + k;
               s_nxt.wave[lo] = s_r.en[lo] &
                  out_level({8'h00, s_nxt.per_act[lo]},
                            {8'h00, s_nxt.dty_act[lo]},
                            s_nxt.ff[lo], s_r.pol[lo]);
            end
         end
      end

      // Shutdown pin synchroniser and gated interrupt.
      s_nxt.sdn_sync = {s_r.sdn_sync[0], shutdown_pin};
      s_nxt.irq = s_r.sdn_irq_en & s_r.sdn_sync[1];

      // Read data is captured in the setup phase; unmapped reads give zero.
      if (apb_req.psel && !apb_req.penable && !apb_req.pwrite) begin
         s_nxt.prdata = 32'h0000_0000;
         if (is_mapped(apb_req.paddr)) begin
            s_nxt.prdata = rd_data(apb_req.paddr, s_r);
         end
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s_r <= STATE_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_comb begin
      apb_rsp.pready = 1'b1;
      apb_rsp.pslverr = apb_req.psel & apb_req.penable &
                        ~is_mapped(apb_req.paddr);
      apb_rsp.prdata = s_r.prdata;
   end

   assign wave_output = s_r.wave;
   assign irq = s_r.irq;

endmodule : pwmc_core
`default_nettype wire

// ---- pwmc_core_asserts.sv ----
// Port checker of the pulse-width core.
`default_nettype none
module pwmc_core_chk (
   // Clock and reset.
   input wire logic clk,
   input wire logic reset,
   // Bus, ticks and pins.
   input wire pwmc_pkg::pwmc_apb_req_t apb_req,
   input wire pwmc_pkg::pwmc_apb_rsp_t apb_rsp,
   input wire pwmc_pkg::pwmc_tick_t tick,
   input wire logic shutdown_pin,
   input wire logic [3:0] wave_output,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   import pwmc_pkg::*;
   logic acc, wr, bnd;
   logic [3:0] en_r, pol_r;
   logic [1:0] join_r;
   logic sdn_r;
   logic [7:0] per_r, dty_r;
   logic [9:0] quiet_r;

   function automatic logic mapped(input logic [7:0] a);
      return a[1:0] == 2'h0 && (a <= 8'h14 || (a >= 8'h20 && a <= 8'h54));
   endfunction : mapped

   assign acc = apb_req.psel && apb_req.penable;
   assign wr = acc && apb_req.pwrite && apb_rsp.pready;
   // Channel 1 boundary levels are judged only after long all-tick quiet.
   assign bnd = quiet_r >= 10'h258 && en_r[1] && !join_r[0];

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         en_r <= '0;
         pol_r <= '0;
         join_r <= '0;
         sdn_r <= 1'b0;
         per_r <= '0;
         dty_r <= '0;
         quiet_r <= '0;
      end else if (wr) begin
         quiet_r <= '0;
         case (apb_req.paddr)
            OFS_ENABLE: en_r <= apb_req.pwdata[3:0];
            OFS_POLARITY: pol_r <= apb_req.pwdata[3:0];
            OFS_PAIR_JOIN: join_r <= apb_req.pwdata[1:0];
            OFS_SHUTDOWN: sdn_r <= apb_req.pwdata[0];
            OFS_PER_BASE + 8'h04: per_r <= apb_req.pwdata[7:0];
            OFS_DTY_BASE + 8'h04: dty_r <= apb_req.pwdata[7:0];
            default: ;
         endcase
      end else if (tick == '1 && quiet_r != 10'h3ff) begin
         quiet_r <= quiet_r + 10'h001;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   a_ready_now: assert property (acc |-> apb_rsp.pready)
      else $error("pready low in access phase");
   a_err_map: assert property (acc |-> apb_rsp.pslverr == !mapped(apb_req.paddr))
      else $error("pslverr does not match address");
   a_rd_unmapped: assert property (acc && !apb_req.pwrite
      && !mapped(apb_req.paddr) |-> apb_rsp.prdata == 32'h0)
      else $error("unmapped read not zero");
   a_rd_enable: assert property (acc && !apb_req.pwrite
      && apb_req.paddr == OFS_ENABLE |-> apb_rsp.prdata[3:0] == en_r)
      else $error("enable readback wrong");
   a_off_low: assert property ((wave_output & ~en_r & ~$past(en_r)) == 4'h0)
      else $error("disabled channel drives its pin");
   a_join_lo_off: assert property (join_r[0] && $past(join_r[0]) |-> !wave_output[0])
      else $error("high-order pin 0 active when joined");
   a_join_up_off: assert property (join_r[1] && $past(join_r[1]) |-> !wave_output[2])
      else $error("high-order pin 2 active when joined");
   a_irq_gated: assert property (!sdn_r && !$past(sdn_r) |-> !irq)
      else $error("interrupt raised while disabled");
   a_per_zero: assert property (bnd && per_r == 8'h00 |-> wave_output[1] == pol_r[1])
      else $error("zero period level wrong");
   a_duty_zero: assert property (bnd && per_r != 8'h00 && dty_r == 8'h00
      |-> wave_output[1] == !pol_r[1])
      else $error("zero duty level wrong");
   a_duty_full: assert property (bnd && per_r != 8'h00 && dty_r >= per_r
      |-> wave_output[1] == pol_r[1])
      else $error("full duty level wrong");
endmodule : pwmc_core_chk
`default_nettype wire

// ---- pwmc_pin_load.sv ----
// Pin load model that counts high samples and rising edges per pin.
`default_nettype none
module pwmc_pin_load (
   // Clock and count clear.
   input wire logic clk,
   input wire logic clr,
   // Pins and counts.
   input wire logic [3:0] pins,
   output logic [3:0][7:0] highs,
   output logic [3:0][7:0] rises
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] prev_r;

   always_ff @(posedge clk) begin
      prev_r <= pins;
      for (int n = 0; n < 4; n++) begin
         if (clr) begin
            highs[n] <= '0;
            rises[n] <= '0;
         end else begin
            highs[n] <= highs[n] + 8'(pins[n]);
            rises[n] <= rises[n] + 8'(pins[n] & !prev_r[n]);
         end
      end
   end
endmodule : pwmc_pin_load
`default_nettype wire

// ---- test_pwmc_core.sv ----
// Self-checking bench of the pulse-width core.
`default_nettype none
module test_pwmc_core;
   timeunit 1ns;
   timeprecision 1ns;
   import pwmc_pkg::*;
   logic clk, reset, shutdown_pin, clr, irq, err;
   pwmc_apb_req_t req;
   pwmc_apb_rsp_t rsp;
   pwmc_tick_t tick;
   logic [3:0] wave;
   logic [3:0][7:0] highs, rises;
   logic [31:0] rd, held;
   logic [7:0] bnd_per [4] = '{8'h00, 8'h04, 8'h04, 8'h04};
   logic [7:0] bnd_dty [4] = '{8'h03, 8'h00, 8'h05, 8'h04};
   logic bnd_pol [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
   logic [7:0] bnd_hi [4] = '{8'h10, 8'h00, 8'h00, 8'h10};
   int n_errors, compares;

   pwmc_core i_dut (.clk(clk), .reset(reset), .apb_req(req), .apb_rsp(rsp),
      .tick(tick), .shutdown_pin(shutdown_pin), .wave_output(wave),
      .irq(irq));
   pwmc_pin_load i_pins (.clk(clk), .clr(clr), .pins(wave), .highs(highs),
      .rises(rises));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
      input string what);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what,
            seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : wrap_up

   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int i;
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      i = 0;
      @(posedge clk);
      while (rsp.pready !== 1'b1 && i < 16) begin
         @(posedge clk);
         i++;
      end
      if (rsp.pready !== 1'b1) begin
         check(0, 1, "pready timeout");
         wrap_up();
      end
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
   endtask : xfer

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask : wr

   task automatic measure(input int n);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : measure

   initial begin
      req = '0;
      tick = '1;
      shutdown_pin = 1'b0;
      clr = 1'b0;
      reset = 1'b1;
      n_errors = 0;
      compares = 0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      xfer(1'b0, OFS_ENABLE, 0);
      check(rd, 0, "enable after reset");
      xfer(1'b0, OFS_CNT_BASE, 0);
      check(rd, 0, "counter after reset");
      check(wave, 0, "pins after reset");
      xfer(1'b0, 8'h18, 0);
      check(err, 1, "unmapped error");
      check(rd, 0, "unmapped data");
      $display("test done: reset and map");
      for (int m = 0; m < 4; m++) begin
         wr(OFS_ENABLE, 0);
         wr(OFS_ALIGN_MODE, m[1]);
         wr(OFS_POLARITY, m[0]);
         wr(OFS_PER_BASE, 4);
         wr(OFS_DTY_BASE, 1);
         wr(OFS_CNT_BASE, 0);
         wr(OFS_ENABLE, 1);
         repeat (20) @(posedge clk);
         measure(40);
         check(highs[0], m[0] ? 10 : 30, "high time");
         check(rises[0], m[1] ? 5 : 10, "pulse count");
      end
      $display("test done: alignment and polarity");
      wr(OFS_ENABLE, 0);
      wr(OFS_ALIGN_MODE, 0);
      for (int k = 0; k < 4; k++) begin
         wr(OFS_ENABLE, 0);
         wr(OFS_POLARITY, {bnd_pol[k], 1'b0});
         wr(OFS_PER_BASE + 8'h04, bnd_per[k]);
         wr(OFS_DTY_BASE + 8'h04, bnd_dty[k]);
         wr(OFS_ENABLE, 4'h2);
         repeat (610) @(posedge clk);
         measure(16);
         check(highs[1], bnd_hi[k], "boundary level");
         if (k == 0) begin
            xfer(1'b0, OFS_CNT_BASE + 8'h04, 0);
            check(rd, 0, "zero period count");
         end
      end
      $display("test done: boundaries");
      wr(OFS_ENABLE, 0);
      wr(OFS_PAIR_JOIN, 4'h2);
      wr(OFS_CLK_CHOICE, 4'h8);
      wr(OFS_ALIGN_MODE, 4'h4);
      wr(OFS_POLARITY, 4'h8);
      wr(OFS_PER_BASE + 8'h08, 0);
      wr(OFS_PER_BASE + 8'h0c, 8);
      wr(OFS_DTY_BASE + 8'h08, 0);
      wr(OFS_DTY_BASE + 8'h0c, 2);
      wr(OFS_JCNT_UPPER, 0);
      tick <= '{a: 1'b1, sa: 1'b1, b: 1'b0, sb: 1'b1};
      wr(OFS_ENABLE, 4'hc);
      repeat (20) @(posedge clk);
      measure(40);
      check(highs[3], 10, "joined high time");
      check(rises[3], 5, "joined pulses");
      check(highs[2], 0, "high-order pin");
      wr(OFS_ENABLE, 0);
      xfer(1'b0, OFS_JCNT_UPPER, 0);
      held = rd;
      repeat (10) @(posedge clk);
      xfer(1'b0, OFS_JCNT_UPPER, 0);
      check(rd, held, "held count");
      wr(OFS_CNT_BASE + 8'h08, 0);
      xfer(1'b0, OFS_JCNT_UPPER, 0);
      check(rd, 0, "joined clear");
      wr(OFS_PAIR_JOIN, 4'h3);
      wr(OFS_ENABLE, 4'h3);
      measure(20);
      check(highs[0], 0, "high-order pin 0");
      wr(OFS_ENABLE, 0);
      wr(OFS_JCNT_LOWER, 0);
      xfer(1'b0, OFS_JCNT_LOWER, 0);
      check(rd, 0, "lower joined clear");
      $display("test done: joined pair");
      tick <= '1;
      wr(OFS_SHUTDOWN, 0);
      shutdown_pin <= 1'b1;
      repeat (8) @(posedge clk);
      @(negedge clk);
      check(irq, 0, "interrupt gated");
      $display("test done: interrupt gating");
      wrap_up();
   end
endmodule : test_pwmc_core

bind pwmc_core pwmc_core_chk i_chk (.clk(clk), .reset(reset),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .tick(tick),
   .shutdown_pin(shutdown_pin), .wave_output(wave_output), .irq(irq));
`default_nettype wire
